// ### rtl/mcg_main_clock.sv
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/10ps

//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - software can switch own APB clock off
// - own APB clock stays off until reset
// - root is generic or ULP loop source
// - one shared 8-bit prescaler feeds all clocks
// - stopped CPU clock means no CPU ticks
// - bus clocks run on while CPU sleeps
// - per-module gate after common bus clock
// - one interrupt line to interrupt controller
// - byte, halfword and word accesses supported
// - write protection blocks protectable register writes
// - non-secure block serves both requester kinds
// - secure block drops non-secure, reads 0, errors
module mcg_main_clock
  import mcg_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  rst_b,
  input  wire logic                  generic_root_source,
  input  wire logic                  ulp_loop_source,
  input  wire logic                  cpuSleep,
  input  wire logic                  guardWrProtect,
  input  wire logic                  guardSecure,
  input  wire logic [MCG_ADDR_W-1:0] awaddr,
  input  wire logic [2:0]            awprot,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [MCG_ADDR_W-1:0] araddr,
  input  wire logic [2:0]            arprot,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  output logic                       cpuClkEn,
  output logic                       busClkEn,
  output mcg_gates_t                 moduleClkEn,
  output logic                       irq,
  output logic                       guardError
);

  //////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] val,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [7:0] divLimit(input logic [7:0] d);
    return (d == 8'h00) ? 8'h00 : d - 8'h01;
  endfunction

  function automatic logic mapped(input logic [7:0] idx);
    return idx == MCG_IDX_CTRL || idx == MCG_IDX_IENCLR ||
           idx == MCG_IDX_IENSET || idx == MCG_IDX_FLAGS ||
           idx == MCG_IDX_CPU_CLOCK_DIVIDER || idx == MCG_IDX_AHB ||
           idx == MCG_IDX_APBA || idx == MCG_IDX_APBB ||
           idx == MCG_IDX_APBC;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // declarations

  mcg_wr_t          wrState;
  logic [MCG_ADDR_W-1:0] wAddr;
  logic             wNonSec;
  logic [31:0]      wData;
  logic [3:0]       wStrb;
  logic             awSeen;
  logic             wSeen;
  logic             doWrite;
  logic [7:0]       wIdx;
  logic             wDrop;
  logic             wProt;
  logic [7:0]       ctrl;
  logic             irqEnable;
  logic             readyFlag;
  logic [7:0]       cpu_clock_divider;
  logic [7:0]       activeDiv;
  logic             divPending;
  logic [7:0]       preCnt;
  logic             rootTick;
  logic             preWrap;
  mcg_gates_t       masks;
  logic [7:0]       rIdx;
  logic             rDrop;
  logic [31:0]      next_rdata;

  //////////////////////////////////////////////////////////////////////////
  // write channel

  assign doWrite = (wrState == MCG_WR_HALF) && awSeen && wSeen;
  assign wIdx    = wAddr[9:2];
  assign wDrop   = guardSecure && wNonSec;
  assign wProt   = guardWrProtect;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wrState <= MCG_WR_IDLE;
      awSeen  <= 1'b0;
      wSeen   <= 1'b0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= MCG_RESP_OKAY;
      wAddr   <= '0;
      wNonSec <= 1'b0;
      wData   <= '0;
      wStrb   <= '0;
    end else begin
      case (wrState)
        MCG_WR_IDLE: begin
          awready <= 1'b1;
          wready  <= 1'b1;
          wrState <= MCG_WR_HALF;
        end
        MCG_WR_HALF: begin
          if (awvalid && awready) begin
            awSeen  <= 1'b1;
            awready <= 1'b0;
            wAddr   <= awaddr;
            wNonSec <= awprot[1];
          end
          if (wvalid && wready) begin
            wSeen  <= 1'b1;
            wready <= 1'b0;
            wData  <= wdata;
            wStrb  <= wstrb;
          end
          if (doWrite) begin
            awSeen  <= 1'b0;
            wSeen   <= 1'b0;
            bvalid  <= 1'b1;
            bresp   <= mapped(wIdx) ? MCG_RESP_OKAY : MCG_RESP_SLVERR;
            wrState <= MCG_WR_RESP;
          end
        end
        MCG_WR_RESP: begin
          if (bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
            wrState <= MCG_WR_HALF;
          end
        end
        default: begin
          wrState <= MCG_WR_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // control registers

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ctrl   <= MCG_CTRL_RST;
      cpu_clock_divider <= MCG_CPU_CLOCK_DIVIDER_RST;
    end else if (doWrite && !wDrop && !wProt && wStrb[0]) begin
      if (wIdx == MCG_IDX_CTRL) begin
        ctrl <= wData[7:0];
      end
      if (wIdx == MCG_IDX_CPU_CLOCK_DIVIDER) begin
        cpu_clock_divider <= wData[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      masks <= '{MCG_MASK_RST, MCG_MASK_RST, MCG_MASK_RST, MCG_MASK_RST};
    end else if (doWrite && !wDrop && !wProt) begin
      case (wIdx)
        MCG_IDX_AHB:  masks.ahb  <= mergeBytes(masks.ahb, wData, wStrb);
        MCG_IDX_APBA: begin
          masks.apbA <= mergeBytes(masks.apbA, wData, wStrb);
          if (!masks.apbA[MCG_SELF_BIT]) begin
            masks.apbA[MCG_SELF_BIT] <= 1'b0;
          end
        end
        MCG_IDX_APBB: masks.apbB <= mergeBytes(masks.apbB, wData, wStrb);
        MCG_IDX_APBC: masks.apbC <= mergeBytes(masks.apbC, wData, wStrb);
        default: begin
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt enable and flag

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irqEnable <= 1'b0;
    end else if (doWrite && !wDrop && wStrb[0]) begin
      if (wIdx == MCG_IDX_IENSET && wData[MCG_RDY_BIT]) begin
        irqEnable <= 1'b1;
      end else if (wIdx == MCG_IDX_IENCLR && wData[MCG_RDY_BIT]) begin
        irqEnable <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      readyFlag <= 1'b0;
    end else if (preWrap && divPending) begin
      readyFlag <= 1'b1;
    end else if (doWrite && !wDrop && wStrb[0] && wIdx == MCG_IDX_FLAGS &&
                 wData[MCG_RDY_BIT]) begin
      readyFlag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= readyFlag && irqEnable;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // root select and prescaler

  assign rootTick = ctrl[MCG_SEL_BIT] ? ulp_loop_source : generic_root_source;
  assign preWrap  = rootTick && (preCnt >= divLimit(activeDiv));

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      preCnt     <= 8'h00;
      activeDiv  <= MCG_CPU_CLOCK_DIVIDER_RST;
      divPending <= 1'b0;
    end else begin
      if (preWrap) begin
        preCnt <= 8'h00;
      end else if (rootTick) begin
        preCnt <= preCnt + 8'h01;
      end
      if (preWrap) begin
        activeDiv  <= cpu_clock_divider;
        divPending <= 1'b0;
      end
      if (doWrite && !wDrop && !wProt && wStrb[0] && wIdx == MCG_IDX_CPU_CLOCK_DIVIDER) begin
        divPending <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cpuClkEn    <= 1'b0;
      busClkEn    <= 1'b0;
      moduleClkEn <= '0;
    end else begin
      cpuClkEn    <= preWrap && !cpuSleep;
      busClkEn    <= preWrap;
      moduleClkEn <= {4{ {32{preWrap}} }} & masks;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read channel

  assign rIdx  = araddr[9:2];
  assign rDrop = guardSecure && arprot[1];

  always_comb begin
    next_rdata = 32'h00000000;
    case (rIdx)
      MCG_IDX_CTRL:   next_rdata[7:0] = ctrl;
      MCG_IDX_IENCLR: next_rdata[MCG_RDY_BIT] = irqEnable;
      MCG_IDX_IENSET: next_rdata[MCG_RDY_BIT] = irqEnable;
      MCG_IDX_FLAGS:  next_rdata[MCG_RDY_BIT] = readyFlag;
      MCG_IDX_CPU_CLOCK_DIVIDER: next_rdata[7:0] = cpu_clock_divider;
      MCG_IDX_AHB:    next_rdata = masks.ahb;
      MCG_IDX_APBA:   next_rdata = masks.apbA;
      MCG_IDX_APBB:   next_rdata = masks.apbB;
      MCG_IDX_APBC:   next_rdata = masks.apbC;
      default:        next_rdata = 32'h00000000;
    endcase
    if (rDrop) begin
      next_rdata = 32'h00000000;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= MCG_RESP_OKAY;
    end else if (rvalid) begin
      if (rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= next_rdata;
      rresp   <= mapped(rIdx) ? MCG_RESP_OKAY : MCG_RESP_SLVERR;
    end else begin
      arready <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      guardError <= 1'b0;
    end else begin
      guardError <= (doWrite && wDrop) || (arvalid && arready && !rvalid && rDrop);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence wrapSleep_s;
    preWrap && cpuSleep;
  endsequence

  cpu_halt_a: assert property (wrapSleep_s |=> !cpuClkEn)
    else $error("cpu tick during sleep");
  bus_run_a: assert property (wrapSleep_s |=> busClkEn && !cpuClkEn)
    else $error("bus tick lost in sleep");
  self_off_a: assert property (!masks.apbA[MCG_SELF_BIT] |=> !masks.apbA[MCG_SELF_BIT])
    else $error("own clock came back");
  gate_mask_a: assert property (preWrap |=> moduleClkEn == $past(masks))
    else $error("gate does not follow mask");
  ns_read_a: assert property (arvalid && arready && !rvalid && rDrop |=> rvalid && rdata == 32'h0 && guardError)
    else $error("non-secure read leaked");
  protect_a: assert property (doWrite && wProt |=> $stable(ctrl) && $stable(cpu_clock_divider) && $stable(masks))
    else $error("protected write took effect");
  flag_set_a: assert property (preWrap && divPending |=>
    readyFlag ##1 irq == $past(irqEnable))
    else $error("ready flag not raised");
  resp_a: assert property (doWrite |=> bvalid)
    else $error("write response missing");
  tick_a: assert property (busClkEn |-> !$past(busClkEn) || $past(activeDiv) <= 8'h01)
    else $error("prescaler wrapped too soon");

endmodule // mcg_main_clock

// ### rtl/mcg_pkg.sv
package mcg_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] MCG_IDX_CTRL   = 8'h00;
  localparam logic [7:0] MCG_IDX_IENCLR = 8'h01;
  localparam logic [7:0] MCG_IDX_IENSET = 8'h02;
  localparam logic [7:0] MCG_IDX_FLAGS  = 8'h03;
  localparam logic [7:0] MCG_IDX_CPU_CLOCK_DIVIDER = 8'h05;
  localparam logic [7:0] MCG_IDX_AHB    = 8'h10;
  localparam logic [7:0] MCG_IDX_APBA   = 8'h14;
  localparam logic [7:0] MCG_IDX_APBB   = 8'h18;
  localparam logic [7:0] MCG_IDX_APBC   = 8'h1C;

  localparam int         MCG_ADDR_W     = 12;
  localparam int         MCG_SEL_BIT    = 0;
  localparam int         MCG_RDY_BIT    = 0;
  localparam int         MCG_SELF_BIT   = 2;

  localparam logic [7:0]  MCG_CTRL_RST   = 8'h00;
  localparam logic [7:0]  MCG_CPU_CLOCK_DIVIDER_RST = 8'h01;
  localparam logic [31:0] MCG_MASK_RST   = 32'hFFFFFFFF;

  localparam logic [1:0] MCG_RESP_OKAY   = 2'h0;
  localparam logic [1:0] MCG_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [31:0] ahb;
    logic [31:0] apbA;
    logic [31:0] apbB;
    logic [31:0] apbC;
  } mcg_gates_t;

  typedef enum logic [1:0] {
    MCG_WR_IDLE = 2'b00,
    MCG_WR_HALF = 2'b01,
    MCG_WR_RESP = 2'b10
  } mcg_wr_t;

endpackage

// ### sim/mcg_far_side.sv
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// processor and bus modules fed by the derived clock enables
module mcg_far_side
  import mcg_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        cpuClkEn,
  input  wire logic        busClkEn,
  input  wire logic        irq,
  input  wire logic        sleepReq,
  output logic             cpuSleep,
  output logic [15:0]      cpuTicks,
  output logic [15:0]      busTicks,
  output logic             irqSeen
);
  // core enters sleep one cycle after its own request
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cpuSleep <= 1'b0;
      cpuTicks <= 16'h0000;
      busTicks <= 16'h0000;
      irqSeen  <= 1'b0;
    end else begin
      cpuSleep <= sleepReq;
      cpuTicks <= cpuTicks + {15'h0000, cpuClkEn};
      busTicks <= busTicks + {15'h0000, busClkEn};
      irqSeen  <= irq;
    end
  end
endmodule // mcg_far_side

// ### sim/main_clock_gating_unit_tb.sv
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
module main_clock_gating_unit_tb
  import mcg_pkg::*;
;
  logic        ref_clk = 1'b0, rst_b = 1'b0, genSrc = 1'b0, ulpSrc = 1'b0;
  logic        sleepReq = 1'b0, wrProt = 1'b0, secure = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [2:0]  awprot = '0, arprot = '0;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
  logic [31:0] wdata = '0, rdata, rd, m, d;
  logic [3:0]  wstrb = '0, s;
  logic [1:0]  bresp, rresp, rs, ws;
  logic        awready, wready, bvalid, arready, rvalid, cpuClkEn, busClkEn;
  logic        irq, guardError, cpuSleep, irqSeen;
  logic [15:0] cpuTicks, busTicks;
  logic [7:0]  dv;
  mcg_gates_t  moduleClkEn;
  logic [7:0]  gi [4] = '{MCG_IDX_AHB, MCG_IDX_APBA, MCG_IDX_APBB, MCG_IDX_APBC};
  logic [31:0] seed = 32'hBB33;
  int          err_count = 0, cmp_count = 0, gErr = 0, g0, n, c, b;

  mcg_main_clock uut (.ref_clk(ref_clk), .rst_b(rst_b), .generic_root_source(genSrc),
    .ulp_loop_source(ulpSrc), .cpuSleep(cpuSleep), .guardWrProtect(wrProt),
    .guardSecure(secure), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .cpuClkEn(cpuClkEn), .busClkEn(busClkEn), .moduleClkEn(moduleClkEn),
    .irq(irq), .guardError(guardError));
  mcg_far_side far (.ref_clk(ref_clk), .rst_b(rst_b), .cpuClkEn(cpuClkEn),
    .busClkEn(busClkEn), .irq(irq), .sleepReq(sleepReq), .cpuSleep(cpuSleep),
    .cpuTicks(cpuTicks), .busTicks(busTicks), .irqSeen(irqSeen));

  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (guardError === 1'b1)
      gErr++;
  end
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] o, x, input logic [3:0] k);
    for (int j = 0; j < 4; j++)
      if (k[j]) o[8*j +: 8] = x[8*j +: 8];
    return o;
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] x, input logic [3:0] k,
                    input logic ns);
    awaddr  <= {2'b00, i, 2'b00};
    awprot  <= {1'b0, ns, 1'b0};
    wdata   <= x;
    wstrb   <= k;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if ((awready & awvalid) === 1'b1)
        awvalid <= 1'b0;
      if ((wready & wvalid) === 1'b1)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    ws = bresp;
  endtask
  task automatic rdr(input logic [7:0] i, input logic ns);
    araddr  <= {2'b00, i, 2'b00};
    arprot  <= {1'b0, ns, 1'b0};
    arvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      if ((arready & arvalid) === 1'b1)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
  endtask
  // enable pulses counted by the far side over a window
  task automatic win(input int k);
    c = cpuTicks;
    b = busTicks;
    cyc(k);
    c = cpuTicks - c;
    b = busTicks - b;
  endtask
  task automatic pulse();
    for (int t = 0; t < 20; t++) begin
      @(posedge ref_clk);
      if (busClkEn === 1'b1)
        break;
    end
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(20000);
    err_count++;
    report_and_stop();
  end
  initial begin
    cyc(2);
    rst_b <= 1'b1;
    cyc(2);
    rdr(MCG_IDX_CTRL, 1'b0);
    chk(rd, MCG_CTRL_RST);
    rdr(MCG_IDX_CPU_CLOCK_DIVIDER, 1'b0);
    chk(rd, MCG_CPU_CLOCK_DIVIDER_RST);
    rdr(8'h04, 1'b0);
    chk({rd, 30'h0, rs}, {32'h0, 30'h0, MCG_RESP_SLVERR});
    wr(8'h04, 32'hFF, 4'hF, 1'b0);
    chk(ws, MCG_RESP_SLVERR);
    genSrc <= 1'b1;
    wr(MCG_IDX_IENSET, 32'h1, 4'h1, 1'b0);
    for (int i = 0; i < 4; i++) begin
      dv = (i == 0) ? 8'h00 : 8'(xs() % 8) + 8'h01;
      n = (dv == 8'h00) ? 1 : int'(dv);
      wr(MCG_IDX_CPU_CLOCK_DIVIDER, {24'h0, dv}, 4'h1, 1'b0);
      cyc(2 * n + 4);
      rdr(MCG_IDX_FLAGS, 1'b0);
      chk(rd[MCG_RDY_BIT], 1'b1);
      chk({irq, irqSeen}, 2'b11);
      win(8 * n);
      chk({c, b}, {32'd8, 32'd8});
      wr(MCG_IDX_FLAGS, 32'h1, 4'h1, 1'b0);
      cyc(3);
      rdr(MCG_IDX_FLAGS, 1'b0);
      chk({rd[MCG_RDY_BIT], irq}, 2'b00);
    end
    wr(MCG_IDX_IENCLR, 32'h1, 4'h1, 1'b0);
    wr(MCG_IDX_CPU_CLOCK_DIVIDER, 32'h2, 4'h1, 1'b0);
    cyc(10);
    rdr(MCG_IDX_FLAGS, 1'b0);
    chk({rd[MCG_RDY_BIT], irq}, 2'b10);
    sleepReq <= 1'b1;
    cyc(8);
    win(16);
    chk({c, b}, {32'd0, 32'd8});
    sleepReq <= 1'b0;
    wr(MCG_IDX_CPU_CLOCK_DIVIDER, 32'h1, 4'h1, 1'b0);
    wr(MCG_IDX_CTRL, 32'h1, 4'h1, 1'b0);
    cyc(4);
    win(10);
    chk(b, 0);
    ulpSrc <= 1'b1;
    genSrc <= 1'b0;
    cyc(4);
    win(10);
    chk(b, 10);
    for (int k = 0; k < 4; k++) begin
      if (k == 1)
        continue;
      m = xs();
      wr(gi[k], m, 4'hF, 1'b0);
      rdr(gi[k], 1'b0);
      chk(rd, m);
      pulse();
      chk(moduleClkEn[127 - 32 * k -: 32], m);
      d = xs();
      s = 4'(xs());
      wr(gi[k], d, s, 1'b0);
      rdr(gi[k], 1'b0);
      chk(rd, merge(m, d, s));
    end
    wr(MCG_IDX_CPU_CLOCK_DIVIDER, 32'h3, 4'h2, 1'b0);
    rdr(MCG_IDX_CPU_CLOCK_DIVIDER, 1'b0);
    chk(rd, 32'h1);
    wr(MCG_IDX_APBA, 32'hFFFFFFFB, 4'hF, 1'b0);
    pulse();
    chk(moduleClkEn.apbA[MCG_SELF_BIT], 1'b0);
    wr(MCG_IDX_APBA, 32'hFFFFFFFF, 4'hF, 1'b0);
    rdr(MCG_IDX_APBA, 1'b0);
    chk(rd, 32'hFFFFFFFB);
    wrProt <= 1'b1;
    wr(MCG_IDX_CPU_CLOCK_DIVIDER, 32'h4, 4'h1, 1'b0);
    wr(MCG_IDX_CTRL, 32'h0, 4'h1, 1'b0);
    rdr(MCG_IDX_CPU_CLOCK_DIVIDER, 1'b0);
    chk(rd, 32'h1);
    rdr(MCG_IDX_CTRL, 1'b0);
    chk(rd, 32'h1);
    wrProt <= 1'b0;
    wr(MCG_IDX_CPU_CLOCK_DIVIDER, 32'h2, 4'h1, 1'b1);
    rdr(MCG_IDX_CPU_CLOCK_DIVIDER, 1'b1);
    chk(rd, 32'h2);
    secure <= 1'b1;
    g0 = gErr;
    rdr(MCG_IDX_CPU_CLOCK_DIVIDER, 1'b1);
    chk({rd, 30'h0, rs}, {32'h0, 30'h0, MCG_RESP_OKAY});
    wr(MCG_IDX_CPU_CLOCK_DIVIDER, 32'h5, 4'h1, 1'b1);
    rdr(MCG_IDX_CPU_CLOCK_DIVIDER, 1'b0);
    chk(rd, 32'h2);
    cyc(2);
    chk(gErr - g0, 2);
    secure <= 1'b0;
    rst_b <= 1'b0;
    cyc(2);
    rst_b <= 1'b1;
    cyc(2);
    rdr(MCG_IDX_APBA, 1'b0);
    chk(rd, MCG_MASK_RST);
    report_and_stop();
  end
endmodule // main_clock_gating_unit_tb
